// ==== include/jpop_map.svh ====
// Register offsets, field positions, reset values and counts of the compressed output port
`ifndef JPOP_MAP_SVH
`define JPOP_MAP_SVH
// Register offsets
`define JPOP_OFS_CFG 8'h0D
`define JPOP_OFS_DIV_A 8'h0E
`define JPOP_OFS_DIV_B 8'h0F
`define JPOP_OFS_SP_LINES 8'h10
`define JPOP_OFS_SP_LEN 8'h11
`define JPOP_OFS_SP_GAP 8'h12
`define JPOP_OFS_STATUS 8'h13
`define JPOP_OFS_LEN_LO 8'h14
`define JPOP_OFS_LEN_HI 8'h15
// Configuration bit positions
`define JPOP_CFG_SPOOF 0
`define JPOP_CFG_LV_GATE 1
`define JPOP_CFG_FV_GATE 2
`define JPOP_CFG_MARKERS 3
`define JPOP_CFG_MK_INSIDE 4
`define JPOP_CFG_SWAP 5
`define JPOP_CFG_ADAPT 6
`define JPOP_CFG_STATUS_APP 7
`define JPOP_CFG_PAD 8
`define JPOP_CFG_KEEP 9
`define JPOP_CFG_RAW 10
// Divisor fields
`define JPOP_DIV_SLOW 7:0
`define JPOP_DIV_MID 15:8
`define JPOP_DIV_FAST 7:0
// Reset values
`define JPOP_CFG_RST 16'h0000
`define JPOP_DIV_A_RST 16'h0408
`define JPOP_DIV_B_RST 16'h0002
`define JPOP_SP_LINES_RST 16'h04B0
`define JPOP_SP_LEN_RST 16'h0640
`define JPOP_SP_GAP_RST 16'h0010
// Marker bytes
`define JPOP_MARK_FF 8'hFF
`define JPOP_MARK_SOI 8'hD8
`define JPOP_MARK_EOI 8'hD9
// Sizes and thresholds
`define JPOP_FIFO_BYTES 1600
`define JPOP_TH_LOW_PCT 25
`define JPOP_TH_MID_PCT 50
`define JPOP_TH_HIGH_PCT 75
`define JPOP_DIV_MIN 8'h02
`define JPOP_READY_MARGIN 4
`define JPOP_TRAIL_LAST 3'h3
`define JPOP_TRAIL_DONE 3'h4
`endif

// ==== include/jpop_pkg.sv ====
// Types shared by the compressed output port
package jpop_pkg;
	// Output sequencer states
	typedef enum logic [2:0] {
		JPOP_IDLE = 3'b000,
		JPOP_SOI = 3'b001,
		JPOP_DATA = 3'b010,
		JPOP_TRAIL = 3'b011,
		JPOP_EOI = 3'b100,
		JPOP_GAP = 3'b101,
		JPOP_LINE = 3'b110
	} jpop_state_t;
	// Adaptive clock speed levels
	typedef enum logic [1:0] {
		JPOP_SLOW = 2'b00,
		JPOP_MID = 2'b01,
		JPOP_FAST = 2'b10
	} jpop_speed_t;
endpackage

// ==== logic/jpop_port.sv ====
// Compressed byte output port with FIFO, spoof timing and adaptive clock
`timescale 1ns/10ps
`default_nettype none
`include "jpop_map.svh"

module jpop_port #(
	parameter int DEPTH = `JPOP_FIFO_BYTES,
	parameter int LEN_W = 24
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	output logic [15:0] reg_rdata,
	input wire logic frame_start,
	input wire logic enc_valid,
	input wire logic [7:0] enc_data,
	input wire logic enc_last,
	output logic enc_ready,
	input wire logic raw_valid,
	input wire logic [9:0] raw_pixel,
	input wire logic raw_last,
	output logic raw_ready,
	output logic [7:0] out_data,
	output logic row_qualifier,
	output logic frame_qualifier,
	output logic output_pixel_clock
);
	import jpop_pkg::*;

	// Threshold levels in bytes
	localparam int TH_LOW = DEPTH * `JPOP_TH_LOW_PCT / 100;
	localparam int TH_MID = DEPTH * `JPOP_TH_MID_PCT / 100;
	localparam int TH_HIGH = DEPTH * `JPOP_TH_HIGH_PCT / 100;
	localparam int READY_LIM = DEPTH - `JPOP_READY_MARGIN;

	// Refuse sizes the pointers cannot hold
	if (DEPTH < 8 || DEPTH > 2047 || LEN_W < 16 || LEN_W > 24) begin : g_chk
		$error("jpop_port: unsupported DEPTH or LEN_W");
	end

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Pointer advance with wrap at the FIFO depth
	function automatic logic [10:0] ptr_add(input logic [10:0] p, input logic [1:0] n);
		logic [11:0] s;
		s = {1'b0, p} + {10'h000, n};
		if (s >= 12'(DEPTH)) begin
			s = s - 12'(DEPTH);
		end
		return s[10:0];
	endfunction

	// Divisor clamped so both clock phases exist
	function automatic logic [7:0] eff_div(input logic [7:0] d);
		return (d < `JPOP_DIV_MIN) ? `JPOP_DIV_MIN : d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] mem [DEPTH]; // Output FIFO storage
	logic [10:0] wr_ptr_reg, rd_ptr_reg; // Storage pointers
	logic [11:0] wr_total_reg, rd_total_reg; // Running byte totals
	logic [11:0] fcount; // Fullness
	logic wr_en; // FIFO write
	logic [7:0] wr_byte; // Byte written
	logic last_wr; // Last byte of image written
	logic raw_accept; // Raw pixel taken
	logic raw_phase_reg; // Low byte pending
	logic [1:0] raw_low_reg; // Held low pixel bits
	logic raw_last_reg; // Held end-of-image
	logic [LEN_W-1:0] byte_cnt_reg, len_reg; // Byte counts
	logic img_done_reg; // Whole image in FIFO
	logic [15:0] cfg_reg, div_a_reg, div_b_reg; // Control registers
	logic [15:0] sp_lines_reg, sp_len_reg, sp_gap_reg; // Spoof shape
	jpop_speed_t speed_reg; // Adaptive level
	logic [7:0] sel_div; // Wanted divisor
	logic [7:0] div_cnt_reg, cur_div_reg; // Clock divider
	logic tick; // Start of output clock period
	logic clk_en_reg; // Clock runs this period
	jpop_state_t state_reg; // Sequencer state
	logic mk_idx_reg; // Marker byte index
	logic [2:0] trl_idx_reg; // Trailer byte index
	logic sw_phase_reg; // Swap pair half
	logic [15:0] pos_reg, line_reg; // Spoof position
	logic start_pend_reg; // Frame requested
	logic trunc_err_reg; // Excess bytes discarded
	logic drop_rest_reg; // Flushing rest of image
	logic swap_now, can_data, finished, line_emit; // Sequencer decisions
	logic [7:0] fifo_byte, trl_byte, status_byte; // Byte sources
	logic [1:0] pop_n; // Bytes released
	logic nx_phase; // Next swap half
	logic [23:0] len24; // Count padded for trailer

	assign fcount = wr_total_reg - rd_total_reg;
	assign tick = ({1'b0, div_cnt_reg} + 9'h001) >= {1'b0, cur_div_reg};

	////////////////////////////////////////////////////////////////////////
	// Write side

	// Source selection into the FIFO
	always_comb begin
		raw_accept = raw_valid && raw_ready;
		if (cfg_reg[`JPOP_CFG_RAW]) begin
			wr_en = raw_phase_reg || raw_accept;
			wr_byte = raw_phase_reg ? {6'h00, raw_low_reg} : raw_pixel[9:2];
			last_wr = raw_phase_reg && raw_last_reg;
		end else begin
			wr_en = enc_valid && enc_ready;
			wr_byte = enc_data;
			last_wr = enc_valid && enc_ready && enc_last;
		end
	end

	// FIFO storage
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_ptr_reg] <= wr_byte;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= 11'h000;
			wr_total_reg <= 12'h000;
		end else if (wr_en) begin
			wr_ptr_reg <= ptr_add(wr_ptr_reg, 2'h1);
			wr_total_reg <= wr_total_reg + 12'h001;
		end
	end

	// Raw pixel splitting
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			raw_phase_reg <= 1'b0;
			raw_low_reg <= 2'h0;
			raw_last_reg <= 1'b0;
		end else if (raw_accept) begin
			raw_phase_reg <= 1'b1;
			raw_low_reg <= raw_pixel[1:0];
			raw_last_reg <= raw_last;
		end else begin
			raw_phase_reg <= 1'b0;
		end
	end

	// Image byte count and completion
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			byte_cnt_reg <= '0;
			len_reg <= '0;
			img_done_reg <= 1'b0;
		end else begin
			if (frame_start) begin
				byte_cnt_reg <= '0;
				img_done_reg <= 1'b0;
			end
			if (wr_en) begin
				byte_cnt_reg <= (frame_start ? '0 : byte_cnt_reg) + 1'b1;
			end
			if (last_wr) begin
				len_reg <= byte_cnt_reg + 1'b1;
				img_done_reg <= 1'b1;
			end
		end
	end

	// Registered back-pressure with room for bytes in flight
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			enc_ready <= 1'b0;
			raw_ready <= 1'b0;
		end else begin
			enc_ready <= !cfg_reg[`JPOP_CFG_RAW] && fcount <= 12'(READY_LIM);
			raw_ready <= cfg_reg[`JPOP_CFG_RAW] && fcount <= 12'(READY_LIM) && !raw_accept;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Register writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_reg <= `JPOP_CFG_RST;
			div_a_reg <= `JPOP_DIV_A_RST;
			div_b_reg <= `JPOP_DIV_B_RST;
			sp_lines_reg <= `JPOP_SP_LINES_RST;
			sp_len_reg <= `JPOP_SP_LEN_RST;
			sp_gap_reg <= `JPOP_SP_GAP_RST;
		end else if (reg_write) begin
			unique case (reg_addr)
				`JPOP_OFS_CFG: cfg_reg <= reg_wdata;
				`JPOP_OFS_DIV_A: div_a_reg <= reg_wdata;
				`JPOP_OFS_DIV_B: div_b_reg <= {8'h00, reg_wdata[`JPOP_DIV_FAST]};
				`JPOP_OFS_SP_LINES: sp_lines_reg <= reg_wdata;
				`JPOP_OFS_SP_LEN: sp_len_reg <= reg_wdata;
				`JPOP_OFS_SP_GAP: sp_gap_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	assign len24 = 24'(len_reg);
	assign status_byte = {5'h00, drop_rest_reg, img_done_reg, trunc_err_reg};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else begin
			unique case (reg_addr)
				`JPOP_OFS_CFG: reg_rdata <= cfg_reg;
				`JPOP_OFS_DIV_A: reg_rdata <= div_a_reg;
				`JPOP_OFS_DIV_B: reg_rdata <= div_b_reg;
				`JPOP_OFS_SP_LINES: reg_rdata <= sp_lines_reg;
				`JPOP_OFS_SP_LEN: reg_rdata <= sp_len_reg;
				`JPOP_OFS_SP_GAP: reg_rdata <= sp_gap_reg;
				`JPOP_OFS_STATUS: reg_rdata <= {8'h00, status_byte};
				`JPOP_OFS_LEN_LO: reg_rdata <= len24[15:0];
				`JPOP_OFS_LEN_HI: reg_rdata <= {8'h00, len24[23:16]};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output clock

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			speed_reg <= JPOP_SLOW;
		end else if (fcount >= 12'(TH_HIGH)) begin
			speed_reg <= JPOP_FAST;
		end else if (fcount >= 12'(TH_MID) && speed_reg == JPOP_SLOW) begin
			speed_reg <= JPOP_MID;
		end else if (fcount <= 12'(TH_LOW)) begin
			speed_reg <= JPOP_SLOW;
		end else if (fcount <= 12'(TH_MID) && speed_reg == JPOP_FAST) begin
			speed_reg <= JPOP_MID;
		end
	end

	// Divisor chosen by level when adaptive
	always_comb begin
		sel_div = div_a_reg[`JPOP_DIV_SLOW];
		if (cfg_reg[`JPOP_CFG_ADAPT]) begin
			unique case (speed_reg)
				JPOP_SLOW: sel_div = div_a_reg[`JPOP_DIV_SLOW];
				JPOP_MID: sel_div = div_a_reg[`JPOP_DIV_MID];
				JPOP_FAST: sel_div = div_b_reg[`JPOP_DIV_FAST];
				default: sel_div = div_a_reg[`JPOP_DIV_SLOW];
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_cnt_reg <= 8'h00;
			cur_div_reg <= `JPOP_DIV_MIN;
			output_pixel_clock <= 1'b0;
		end else if (tick) begin
			// new divisor only at period end
			div_cnt_reg <= 8'h00;
			cur_div_reg <= eff_div(sel_div);
			output_pixel_clock <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
			// rise mid-period, data launched at fall
			output_pixel_clock <= clk_en_reg && (div_cnt_reg + 8'h01) >= {1'b0, cur_div_reg[7:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer decisions

	always_comb begin
		swap_now = cfg_reg[`JPOP_CFG_SWAP] && cfg_reg[`JPOP_CFG_SPOOF];
		can_data = fcount != 12'h000 && (!swap_now || sw_phase_reg || fcount >= 12'h002
			|| img_done_reg);
		fifo_byte = mem[rd_ptr_reg];
		pop_n = 2'h1;
		nx_phase = 1'b0;
		if (swap_now && !sw_phase_reg && fcount >= 12'h002) begin
			fifo_byte = mem[ptr_add(rd_ptr_reg, 2'h1)];
			pop_n = 2'h0;
			nx_phase = 1'b1;
		end else if (swap_now && sw_phase_reg) begin
			pop_n = 2'h2;
		end
		unique case (trl_idx_reg)
			3'h0: trl_byte = len24[23:16];
			3'h1: trl_byte = len24[15:8];
			3'h2: trl_byte = len24[7:0];
			default: trl_byte = status_byte;
		endcase
		finished = img_done_reg && fcount == 12'h000 && trl_idx_reg == `JPOP_TRAIL_DONE;
		line_emit = can_data || (img_done_reg && fcount == 12'h000
			&& trl_idx_reg != `JPOP_TRAIL_DONE) || (finished && cfg_reg[`JPOP_CFG_PAD]);
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	// byte bus with row and frame qualifiers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= JPOP_IDLE;
			frame_qualifier <= 1'b0;
			row_qualifier <= 1'b0;
			out_data <= 8'h00;
			clk_en_reg <= 1'b0;
			mk_idx_reg <= 1'b0;
			trl_idx_reg <= 3'h0;
			sw_phase_reg <= 1'b0;
			pos_reg <= 16'h0000;
			line_reg <= 16'h0000;
			start_pend_reg <= 1'b0;
			trunc_err_reg <= 1'b0;
			drop_rest_reg <= 1'b0;
			rd_ptr_reg <= 11'h000;
			rd_total_reg <= 12'h000;
		end else begin
			// Flush discarded bytes until image end
			if (drop_rest_reg) begin
				rd_ptr_reg <= wr_ptr_reg;
				rd_total_reg <= wr_total_reg;
				drop_rest_reg <= !img_done_reg;
			end
			if (tick) begin
				unique case (state_reg)
					JPOP_IDLE: begin
						row_qualifier <= 1'b0;
						frame_qualifier <= 1'b0;
						clk_en_reg <= !(cfg_reg[`JPOP_CFG_FV_GATE]
							|| (!cfg_reg[`JPOP_CFG_SPOOF] && cfg_reg[`JPOP_CFG_LV_GATE]));
						if (start_pend_reg && !drop_rest_reg) begin
							start_pend_reg <= 1'b0;
							trunc_err_reg <= 1'b0;
							sw_phase_reg <= 1'b0;
							pos_reg <= 16'h0000;
							line_reg <= 16'h0000;
							mk_idx_reg <= 1'b0;
							trl_idx_reg <= cfg_reg[`JPOP_CFG_SPOOF] ? 3'h0 : `JPOP_TRAIL_LAST;
							if (cfg_reg[`JPOP_CFG_SPOOF]) begin
								frame_qualifier <= 1'b1;
								state_reg <= JPOP_GAP;
							end else if (cfg_reg[`JPOP_CFG_MARKERS]) begin
								state_reg <= JPOP_SOI;
							end else begin
								state_reg <= JPOP_DATA;
							end
						end
					end
					JPOP_SOI: begin
						row_qualifier <= 1'b0;
						frame_qualifier <= cfg_reg[`JPOP_CFG_MK_INSIDE];
						clk_en_reg <= 1'b1;
						out_data <= mk_idx_reg ? `JPOP_MARK_SOI : `JPOP_MARK_FF;
						mk_idx_reg <= !mk_idx_reg;
						if (mk_idx_reg) begin
							state_reg <= JPOP_DATA;
						end
					end
					JPOP_DATA: begin
						frame_qualifier <= 1'b1;
						if (can_data) begin
							out_data <= fifo_byte;
							row_qualifier <= 1'b1;
							clk_en_reg <= 1'b1;
							rd_ptr_reg <= ptr_add(rd_ptr_reg, pop_n);
							rd_total_reg <= rd_total_reg + {10'h000, pop_n};
						end else begin
							// clock gated or free while idle
							row_qualifier <= 1'b0;
							clk_en_reg <= !cfg_reg[`JPOP_CFG_LV_GATE];
							if (img_done_reg) begin
								if (cfg_reg[`JPOP_CFG_STATUS_APP]) begin
									state_reg <= JPOP_TRAIL;
								end else begin
									state_reg <= cfg_reg[`JPOP_CFG_MARKERS] ? JPOP_EOI : JPOP_IDLE;
								end
							end
						end
					end
					JPOP_TRAIL: begin
						out_data <= trl_byte;
						row_qualifier <= 1'b1;
						clk_en_reg <= 1'b1;
						trl_idx_reg <= `JPOP_TRAIL_DONE;
						state_reg <= cfg_reg[`JPOP_CFG_MARKERS] ? JPOP_EOI : JPOP_IDLE;
					end
					JPOP_EOI: begin
						row_qualifier <= 1'b0;
						frame_qualifier <= cfg_reg[`JPOP_CFG_MK_INSIDE];
						clk_en_reg <= 1'b1;
						out_data <= mk_idx_reg ? `JPOP_MARK_EOI : `JPOP_MARK_FF;
						mk_idx_reg <= !mk_idx_reg;
						if (mk_idx_reg) begin
							state_reg <= JPOP_IDLE;
						end
					end
					JPOP_GAP: begin
						row_qualifier <= 1'b0;
						clk_en_reg <= 1'b1;
						if (line_reg >= sp_lines_reg && finished) begin
							state_reg <= JPOP_IDLE;
						end else if (line_reg >= sp_lines_reg && !cfg_reg[`JPOP_CFG_KEEP]) begin
							trunc_err_reg <= 1'b1;
							drop_rest_reg <= 1'b1;
							state_reg <= JPOP_IDLE;
						end else if (({1'b0, pos_reg} + 17'h00001) >= {1'b0, sp_gap_reg}) begin
							pos_reg <= 16'h0000;
							state_reg <= JPOP_LINE;
						end else begin
							pos_reg <= pos_reg + 16'h0001;
						end
					end
					JPOP_LINE: begin
						row_qualifier <= 1'b1;
						clk_en_reg <= line_emit;
						if (can_data) begin
							out_data <= fifo_byte;
							sw_phase_reg <= nx_phase;
							rd_ptr_reg <= ptr_add(rd_ptr_reg, pop_n);
							rd_total_reg <= rd_total_reg + {10'h000, pop_n};
						end else if (line_emit && !finished) begin
							out_data <= trl_byte;
							trl_idx_reg <= trl_idx_reg + 3'h1;
						end else if (line_emit) begin
							out_data <= 8'h00;
						end else if (finished) begin
							row_qualifier <= 1'b0;
							state_reg <= JPOP_IDLE;
						end
						if (line_emit) begin
							if (({1'b0, pos_reg} + 17'h00001) >= {1'b0, sp_len_reg}) begin
								pos_reg <= 16'h0000;
								line_reg <= line_reg + 16'h0001;
								state_reg <= JPOP_GAP;
							end else begin
								pos_reg <= pos_reg + 16'h0001;
							end
						end
					end
					default: state_reg <= JPOP_IDLE;
				endcase
			end
			// Frame request wins over its clear
			if (frame_start) begin
				start_pend_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/jpop_host_model.sv ====
// Host capture port model sampling the compressed byte stream
`timescale 1ns/10ps
`default_nettype none
module jpop_host_model (
	input wire logic output_pixel_clock,
	input wire logic frame_qualifier,
	input wire logic row_qualifier,
	input wire logic [7:0] out_data
);
	logic [7:0] row_q[$]; // Bytes taken while row qualifier high
	logic [8:0] frm_q[$]; // Every frame sample as {row, byte}
	////////////////////////////////////////////////////////////////
	// sample on clock rise
	always @(posedge output_pixel_clock) begin
		if (frame_qualifier) begin
			frm_q.push_back({row_qualifier, out_data});
			if (row_qualifier) begin
				row_q.push_back(out_data);
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/jpop_port_asserts.sv ====
// Concurrent checks on the compressed output port pins
`timescale 1ns/10ps
`default_nettype none
`include "jpop_map.svh"
module jpop_port_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic [15:0] reg_rdata,
	input wire logic enc_ready,
	input wire logic raw_valid,
	input wire logic raw_ready,
	input wire logic [7:0] out_data,
	input wire logic row_qualifier,
	input wire logic frame_qualifier,
	input wire logic output_pixel_clock
);
	logic [15:0] cfg_reg; // Shadow of the configuration register
	logic [4:0] idle_reg; // Cycles idle between frames with gating on
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	// Track configuration writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_reg <= `JPOP_CFG_RST;
		end else if (reg_write && reg_addr == `JPOP_OFS_CFG) begin
			cfg_reg <= reg_wdata;
		end
	end
	// Count gated idle time, long enough for a period of up to 31 cycles to end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_reg <= 5'h00;
		end else if (frame_qualifier || !cfg_reg[`JPOP_CFG_FV_GATE]) begin
			idle_reg <= 5'h00;
		end else if (idle_reg != 5'h1F) begin
			idle_reg <= idle_reg + 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////
	row_in_frame_a: assert property (row_qualifier |-> frame_qualifier)
		else $error("row qualifier high outside frame");
	hold_while_high_a: assert property (output_pixel_clock |->
		$stable(out_data) && $stable(row_qualifier) && $stable(frame_qualifier))
		else $error("output moved while output clock high");
	clk_high_bound_a: assert property ($rose(output_pixel_clock) |->
		##[1:128] !output_pixel_clock)
		else $error("output clock high phase too long");
	idle_gated_a: assert property ((idle_reg == 5'h1F) |-> !output_pixel_clock)
		else $error("output clock runs between frames");
	raw_blocks_enc_a: assert property (cfg_reg[`JPOP_CFG_RAW] && $past(cfg_reg[`JPOP_CFG_RAW]) |-> !enc_ready)
		else $error("encoder ready during raw bypass");
	raw_pace_a: assert property (raw_valid && raw_ready |=> !raw_ready)
		else $error("raw ready not dropped for second byte");
	cfg_readback_a: assert property ((reg_addr == `JPOP_OFS_CFG) |=> reg_rdata == $past(cfg_reg))
		else $error("configuration read mismatch");
	status_width_a: assert property ((reg_addr == `JPOP_OFS_STATUS) |=> reg_rdata[15:3] == 13'h0000)
		else $error("status upper bits set");
	len_high_a: assert property ((reg_addr == `JPOP_OFS_LEN_HI) |=> reg_rdata[15:8] == 8'h00)
		else $error("byte count high word too wide");
	unmapped_read_a: assert property ((reg_addr < 8'h0D || reg_addr > 8'h15) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	row_seen_c: cover property ($rose(row_qualifier));
	frame_end_c: cover property ($fell(frame_qualifier));
	raw_taken_c: cover property (raw_valid && raw_ready);
	idle_gate_c: cover property (idle_reg == 5'h1F);
endmodule
`default_nettype wire

// ==== sim/jpop_port_test.sv ====
// Self-checking bench for the compressed output port
`timescale 1ns/10ps
`default_nettype none
`include "jpop_map.svh"
module jpop_port_test;
	logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, frame_start = 1'b0;
	logic enc_valid = 1'b0, enc_last = 1'b0, raw_valid = 1'b0, raw_last = 1'b0;
	logic [7:0] reg_addr = 8'h00, enc_data = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
	logic [9:0] raw_pixel = 10'h000;
	logic [7:0] out_data;
	logic row_qualifier, frame_qualifier, output_pixel_clock, enc_ready, raw_ready;
	int n_errors = 0, n_compared = 0, cyc = 0, i;
	logic [7:0] exp_q[$]; // Bytes fed this frame
	logic [7:0] ra[7] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h20};
	logic [15:0] rv[7] = '{`JPOP_CFG_RST, `JPOP_DIV_A_RST, `JPOP_DIV_B_RST,
		`JPOP_SP_LINES_RST, `JPOP_SP_LEN_RST, `JPOP_SP_GAP_RST, 16'h0000};
	always #20 clk = ~clk;
	jpop_port u_jpop_port (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .enc_valid(enc_valid), .enc_data(enc_data),
		.enc_last(enc_last), .enc_ready(enc_ready), .raw_valid(raw_valid),
		.raw_pixel(raw_pixel), .raw_last(raw_last), .raw_ready(raw_ready),
		.out_data(out_data), .row_qualifier(row_qualifier),
		.frame_qualifier(frame_qualifier), .output_pixel_clock(output_pixel_clock));
	jpop_host_model u_jpop_host_model (.output_pixel_clock(output_pixel_clock),
		.frame_qualifier(frame_qualifier), .row_qualifier(row_qualifier), .out_data(out_data));
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task conclude();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Register access, one write pulse
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clk);
		reg_write = 1'b0;
	endtask
	// Read data is registered one edge after address
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask
	// Feed n encoder bytes or n raw pixels, waiting on ready
	task feed(input int n, input bit raw);
		int k;
		exp_q.delete();
		@(negedge clk);
		for (k = 0; k < n; k++) begin
			if (raw) begin
				raw_valid = 1'b1;
				raw_pixel = 10'h2B5;
				raw_last = 1'b1;
			end else begin
				enc_valid = 1'b1;
				enc_data = 8'h3C + 8'(8'h47 * k);
				enc_last = (k == n - 1);
				exp_q.push_back(enc_data);
			end
			while ((raw ? raw_ready : enc_ready) !== 1'b1) @(negedge clk);
			@(negedge clk);
		end
		enc_valid = 1'b0;
		enc_last = 1'b0;
		raw_valid = 1'b0;
		raw_last = 1'b0;
	endtask
	// One frame: configure, request, feed, wait for frame end
	task run(input logic [15:0] cfg, input int n, input bit raw);
		int k;
		wr(`JPOP_OFS_CFG, cfg);
		u_jpop_host_model.row_q.delete();
		u_jpop_host_model.frm_q.delete();
		@(negedge clk);
		frame_start = 1'b1;
		@(negedge clk);
		frame_start = 1'b0;
		feed(n, raw);
		// Frame may open before the bytes are in, so wait for it to open, then to close
		k = 0;
		while (frame_qualifier !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		while (frame_qualifier !== 1'b0 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 4000) begin
			n_errors++;
			$display("ERROR %0t frame never ended", $time);
		end
		repeat (24) @(negedge clk);
	endtask
	// Cut a hung run short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			$display("ERROR %0t run too long", $time);
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge clk);
		reset = 1'b0;
		for (i = 0; i < 7; i++) begin
			rd(ra[i], v);
			chk(v, rv[i]);
		end
		wr(`JPOP_OFS_DIV_B, 16'h0003);
		rd(`JPOP_OFS_DIV_B, v);
		chk(v, 16'h0003);
		wr(`JPOP_OFS_DIV_B, `JPOP_DIV_B_RST);
		wr(`JPOP_OFS_STATUS, 16'hFFFF);
		rd(`JPOP_OFS_STATUS, v);
		chk(v, 16'h0000);
		// Continuous, markers inside frame, status appended
		run(16'h009C, 3, 1'b0);
		chk(16'(u_jpop_host_model.frm_q[0]), 16'h00FF);
		chk(16'(u_jpop_host_model.frm_q[1]), 16'h00D8);
		chk(16'(u_jpop_host_model.frm_q[$ - 1]), 16'h00FF);
		chk(16'(u_jpop_host_model.frm_q[$]), 16'h00D9);
		for (i = 0; i < 3; i++) chk(16'(u_jpop_host_model.row_q[i]), 16'(exp_q[i]));
		chk(16'(u_jpop_host_model.row_q[3]), 16'h0002);
		chk(16'(u_jpop_host_model.frm_q.size()), 16'd9);
		rd(`JPOP_OFS_LEN_LO, v);
		chk(v, 16'h0003);
		rd(`JPOP_OFS_STATUS, v);
		chk(v, 16'h0002);
		// Same frame with clock gated while no data byte is ready
		run(16'h009E, 3, 1'b0);
		chk(16'(u_jpop_host_model.frm_q.size()), 16'd8);
		// Spoof frame of 4 lines of 4, padded
		wr(`JPOP_OFS_SP_LINES, 16'h0004);
		wr(`JPOP_OFS_SP_LEN, 16'h0004);
		wr(`JPOP_OFS_SP_GAP, 16'h0002);
		run(16'h0105, 4, 1'b0);
		chk(16'(u_jpop_host_model.row_q.size()), 16'd16);
		for (i = 0; i < 8; i++) chk(16'(u_jpop_host_model.row_q[i]), (i < 4) ? 16'(exp_q[i])
			: (i == 6) ? 16'h0004 : (i == 7) ? 16'h0002 : 16'h0000);
		// Spoof with pair swap, then swap bit in continuous
		run(16'h0125, 4, 1'b0);
		for (i = 0; i < 4; i++) chk(16'(u_jpop_host_model.row_q[i]), 16'(exp_q[i ^ 1]));
		run(16'h0024, 4, 1'b0);
		for (i = 0; i < 4; i++) chk(16'(u_jpop_host_model.row_q[i]), 16'(exp_q[i]));
		// Short spoof frame discards excess
		wr(`JPOP_OFS_SP_LINES, 16'h0001);
		wr(`JPOP_OFS_SP_LEN, 16'h0002);
		run(16'h0005, 4, 1'b0);
		chk(16'(u_jpop_host_model.row_q.size()), 16'd2);
		rd(`JPOP_OFS_STATUS, v);
		chk(v, 16'h0003);
		// Short spoof frame keeps excess bytes
		run(16'h0205, 4, 1'b0);
		chk(16'(u_jpop_host_model.row_q.size()), 16'd8);
		chk(16'(u_jpop_host_model.row_q[3]), 16'(exp_q[3]));
		// Raw bypass pixel split into two bytes
		run(16'h0404, 1, 1'b1);
		chk(16'(u_jpop_host_model.row_q[0]), 16'h00AD);
		chk(16'(u_jpop_host_model.row_q[1]), 16'h0001);
		conclude();
	end
endmodule
bind jpop_port jpop_port_asserts u_jpop_port_asserts (.clk(clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_rdata(reg_rdata), .enc_ready(enc_ready), .raw_valid(raw_valid),
	.raw_ready(raw_ready), .out_data(out_data), .row_qualifier(row_qualifier),
	.frame_qualifier(frame_qualifier), .output_pixel_clock(output_pixel_clock));
`default_nettype wire
